// [logic/ddr2_ctl_map.svh]
// Purpose: Offsets, field positions, reset values and counts for the pin control block
// Assumes: Included by the design modules and the checker
// Notes: Definitions only
`ifndef DDR2_CTL_MAP_SVH
`define DDR2_CTL_MAP_SVH

`define ROW_W_DEF 13
`define BANK_W_DEF 2
`define DQ_W_DEF 16
`define BYTES_DEF 2
`define COL_W 10
`define AP_BIT 10
`define EMR1_SEL 2'h1
`define EMR_RTT_LO 2
`define EMR_RTT_HI 6
`define ODT_DIS_RST 1'b0
`define CKE_RST 1'b0

`endif

// [logic/ddr2_ctl_pkg.sv]
// Purpose: Types shared by the pin control modules
// Assumes: Encodings ordered as chip select, row, column, write strobe
// Notes: Power states use Gray codes along active, down, self refresh
package ddr2_ctl_pkg;

  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_RSV = 4'h6,
    CMD_NOP = 4'h7,
    CMD_DESEL = 4'h8
  } cmd_t;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h0,
    ST_PD_PRE = 2'h1,
    ST_PD_ACT = 2'h3,
    ST_SREF = 2'h2
  } pwr_t;

endpackage : ddr2_ctl_pkg

// [logic/cmd_bus_if.sv]
// Purpose: Carries sampled pins from the sampler to the power and command logic
// Assumes: One clock domain
// Notes: Enables flow back to the sampler
`timescale 1ns/100ps
interface cmd_bus_if #(parameter int ROW_W = 13, parameter int BANK_W = 2);
  import ddr2_ctl_pkg::*;
  logic cke;
  cmd_t cmd;
  logic [BANK_W-1:0] ba;
  logic [ROW_W-1:0] addr;
  logic odt;
  logic samp_cmd;
  logic samp_cke;
  modport src(output cke, cmd, ba, addr, odt, input samp_cmd, samp_cke);
  modport dst(input cke, cmd, ba, addr, odt, output samp_cmd, samp_cke);
endinterface : cmd_bus_if

// [logic/pin_sampler.sv]
// Purpose: Registers control and address pins on the rising clock and decodes commands
// Assumes: Pins synchronous to ref_clk
// Notes: Disabled buffers read as deselect, termination low
`timescale 1ns/100ps
`include "ddr2_ctl_map.svh"
module pin_sampler #(
  parameter int ROW_W = `ROW_W_DEF,
  parameter int BANK_W = `BANK_W_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ROW_W-1:0] addr,
  cmd_bus_if.src bus
);
  import ddr2_ctl_pkg::*;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [BANK_W-1:0] ba;
    logic [ROW_W-1:0] addr;
  } samp_t;

  samp_t s;
  samp_t next_s;

  always_comb
  begin
    next_s = s;
    if (bus.samp_cke)
      next_s.cke = cke;
    if (bus.samp_cmd)
    begin
      next_s.cs_n = cs_n;
      next_s.ras_n = ras_n;
      next_s.cas_n = cas_n;
      next_s.we_n = we_n;
      next_s.odt = odt;
      next_s.ba = ba;
      next_s.addr = addr;
    end
    else
    begin
      // Buffer off: nothing reaches the decoder
      next_s.cs_n = 1'b1;
      next_s.odt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      s <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
    else if (ce)
      s <= next_s;
  end

  always_comb
  begin
    if (s.cs_n)
      bus.cmd = CMD_DESEL;
    else
      bus.cmd = cmd_t'({1'b0, s.ras_n, s.cas_n, s.we_n});
  end

  assign bus.cke = s.cke;
  assign bus.ba = s.ba;
  assign bus.addr = s.addr;
  assign bus.odt = s.odt;
endmodule : pin_sampler

// [logic/ddr2_pin_ctrl.sv]
// Purpose: Command and control pin behaviour of a DDR2 memory device
// Assumes: All pins synchronous to ref_clk except clock enable on self-refresh exit
//   The strobe domain has already been brought onto ref_clk as beat levels
// Notes: Data strobe edges arrive as separate rise and fall beat inputs
//   Commands decode two edges after the pins: one edge samples, one decodes
//   Bank tracking assumes the controller keeps legal command spacing
// Operation
// - Clock enable high runs internal clocks, buffers, drivers; low stops them.
// - Clock enable low: idle banks give power down or self refresh; open gives active.
// - Clock enable sampled on clock for power-down entry, exit and self-refresh entry.
// - Self-refresh exit takes clock enable asynchronously.
// - Power down disables all input buffers but the clock pair and clock enable.
// - Self refresh disables all input buffers but clock enable.
// - Commands are ignored while chip select is registered high.
// - Command decoded from chip select, row, column and write strobes.
// - Termination input high enables termination on data, strobes and masks.
// - Termination input ignored when extended mode register disables termination.
// - A write beat with its mask high is not written; mask taken both edges.
// - Bank address picks the bank for activate, read, write, precharge.
// - Bank address picks base or extended mode register on mode set.
// - Address carries row on activate; column and auto-precharge on read/write.
// - Precharge with address ten low hits one bank; high hits all banks.
// - Mode register set takes its operation code from the address inputs.
// - Control and address sampled on the rising clock edge, presented aligned.
`timescale 1ns/100ps
`include "ddr2_ctl_map.svh"
module ddr2_pin_ctrl #(
  parameter int ROW_W = `ROW_W_DEF,
  parameter int BANK_W = `BANK_W_DEF,
  parameter int DQ_W = `DQ_W_DEF,
  parameter int BYTES = `BYTES_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ROW_W-1:0] addr,
  input wire logic beat_rise,
  input wire logic beat_fall,
  input wire logic [BYTES-1:0] dm_rise,
  input wire logic [BYTES-1:0] dm_fall,
  output ddr2_ctl_pkg::pwr_t pwr_state,
  output logic int_clk_en,
  output logic ck_buf_en,
  output logic cmd_buf_en,
  output logic out_drv_en,
  output logic cmd_valid,
  output ddr2_ctl_pkg::cmd_t cmd_code,
  output logic [BANK_W-1:0] cmd_bank,
  output logic [ROW_W-1:0] row_addr,
  output logic [`COL_W-1:0] col_addr,
  output logic auto_pre,
  output logic [(1<<BANK_W)-1:0] pre_banks,
  output logic [(1<<BANK_W)-1:0] bank_open,
  output logic mode_wr,
  output logic [BANK_W-1:0] mode_sel,
  output logic [ROW_W-1:0] mode_op,
  output logic [DQ_W+3*BYTES-1:0] term_en,
  output logic [BYTES-1:0] wr_en_rise,
  output logic [BYTES-1:0] wr_en_fall
);
  import ddr2_ctl_pkg::*;

  // One bit per bank for open-row and precharge masks
  localparam int NB = 1 << BANK_W;
  localparam int TW = DQ_W + 3 * BYTES;

  generate
    // Auto-precharge bit and column must fit the address; bytes must split data
    if (ROW_W <= `AP_BIT || ROW_W < `COL_W || BANK_W < 1 || BYTES < 1
        || DQ_W % BYTES != 0)
      $error("ddr2_pin_ctrl: unsupported widths");
  endgenerate

  // All state in one record, registered whole on every enabled edge
  typedef struct packed {
    pwr_t st;
    logic cke_meta;
    logic cke_sync;
    logic odt_dis;
    logic int_clk_en;
    logic ck_buf_en;
    logic cmd_buf_en;
    logic out_drv_en;
    logic cmd_valid;
    cmd_t cmd_code;
    logic [BANK_W-1:0] cmd_bank;
    logic [ROW_W-1:0] row_addr;
    logic [`COL_W-1:0] col_addr;
    logic auto_pre;
    logic [NB-1:0] pre_banks;
    logic [NB-1:0] bank_open;
    logic mode_wr;
    logic [BANK_W-1:0] mode_sel;
    logic [ROW_W-1:0] mode_op;
    logic [TW-1:0] term_en;
    logic [BYTES-1:0] wr_en_rise;
    logic [BYTES-1:0] wr_en_fall;
  } ctl_t;

  ctl_t s;
  ctl_t next_s;

  // Pins are registered once in the sampler and decoded here one edge later
  cmd_bus_if #(.ROW_W(ROW_W), .BANK_W(BANK_W)) bus ();

  pin_sampler #(.ROW_W(ROW_W), .BANK_W(BANK_W)) u_samp (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .cke(cke),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .odt(odt),
    .ba(ba),
    .addr(addr),
    .bus(bus.src)
  );

  // Command buffers follow the registered power state
  assign bus.samp_cmd = s.cmd_buf_en;
  // Clock enable is taken whenever the next state is not self refresh, so the first
  // awake cycle after self refresh never meets a stale low and drops back
  assign bus.samp_cke = next_s.st != ST_SREF;

  // Decode helpers, all but the write enables from sampled pins
  logic cke_fall;
  logic act_cmd;
  logic [NB-1:0] one_bank;
  logic [BYTES-1:0] next_wr_rise;
  logic [BYTES-1:0] next_wr_fall;

  assign one_bank = NB'(1) << bus.ba;
  // A fall needs a sampled high before the sampled low
  assign cke_fall = s.cke_sync && !bus.cke;
  assign act_cmd = s.st == ST_ACTIVE && bus.cke;

  // Masked beats never reach the array; both strobe edges counted
  generate
    for (genvar b = 0; b < BYTES; b++)
    begin : g_mask
      assign next_wr_rise[b] = s.int_clk_en && beat_rise && !dm_rise[b];
      assign next_wr_fall[b] = s.int_clk_en && beat_fall && !dm_fall[b];
    end
  endgenerate

  always_comb
  begin
    next_s = s;
    next_s.cmd_valid = 1'b0;
    next_s.mode_wr = 1'b0;
    next_s.wr_en_rise = next_wr_rise;
    next_s.wr_en_fall = next_wr_fall;

    // Self-refresh exit rides on a free-running synchroniser, not the gated
    // internal clock, so a stopped internal clock cannot block the wake-up
    next_s.cke_meta = cke;
    if (s.st == ST_SREF)
      next_s.cke_sync = s.cke_meta;
    else
      next_s.cke_sync = bus.cke;

    case (s.st)
      ST_ACTIVE:
      begin
        if (cke_fall)
        begin
          // A refresh sampled with the fall asks for self refresh
          if (bus.cmd == CMD_REF)
            next_s.st = ST_SREF;
          else if (|s.bank_open)
            next_s.st = ST_PD_ACT;
          else
            next_s.st = ST_PD_PRE;
        end
      end
      ST_PD_PRE, ST_PD_ACT:
      begin
        // Exit is an ordinary sampled level; the clock still runs
        if (bus.cke)
          next_s.st = ST_ACTIVE;
      end
      ST_SREF:
      begin
        // Free-running pair, not the sampler, carries the wake-up
        if (s.cke_sync)
          next_s.st = ST_ACTIVE;
      end
      // Unused code heals to the awake state
      default:
        next_s.st = ST_ACTIVE;
    endcase

    // Internal clocks and drivers only while awake
    next_s.int_clk_en = next_s.st == ST_ACTIVE;
    next_s.out_drv_en = next_s.st == ST_ACTIVE;
    next_s.cmd_buf_en = next_s.st == ST_ACTIVE;
    next_s.ck_buf_en = next_s.st != ST_SREF;

    if (act_cmd)
    begin
      next_s.cmd_code = bus.cmd;
      // NOP and deselect still show in cmd_code, without a valid pulse
      next_s.cmd_valid = bus.cmd != CMD_DESEL && bus.cmd != CMD_NOP;
      case (bus.cmd)
        CMD_ACT:
        begin
          next_s.cmd_bank = bus.ba;
          next_s.row_addr = bus.addr;
          // Row stays open until a precharge or auto precharge
          next_s.bank_open = s.bank_open | one_bank;
        end
        CMD_RD, CMD_WR:
        begin
          next_s.cmd_bank = bus.ba;
          next_s.col_addr = bus.addr[`COL_W-1:0];
          next_s.auto_pre = bus.addr[`AP_BIT];
          // Auto precharge closes the row on the edge that decodes the access
          if (bus.addr[`AP_BIT])
            next_s.bank_open = s.bank_open & ~one_bank;
        end
        CMD_PRE:
        begin
          next_s.cmd_bank = bus.ba;
          // Address ten chooses one bank or all of them
          if (bus.addr[`AP_BIT])
            next_s.pre_banks = '1;
          else
            next_s.pre_banks = one_bank;
          next_s.bank_open = s.bank_open & ~next_s.pre_banks;
        end
        CMD_MRS:
        begin
          next_s.mode_wr = 1'b1;
          next_s.mode_sel = bus.ba;
          next_s.mode_op = bus.addr;
          // Only the first extended register holds the termination setting
          if (bus.ba == `EMR1_SEL)
            next_s.odt_dis = !bus.addr[`EMR_RTT_LO] && !bus.addr[`EMR_RTT_HI];
        end
        default:
        begin
          next_s.cmd_code = bus.cmd;
        end
      endcase
    end

    // One enable per terminated pin: data, strobe, strobe complement, mask
    // Power down and self refresh drop termination as well
    for (int i = 0; i < TW; i++)
      next_s.term_en[i] = bus.odt && !s.odt_dis && next_s.st == ST_ACTIVE;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      // Wake up with every buffer and driver on and no row open
      s <= '0;
      s.st <= ST_ACTIVE;
      s.cmd_code <= CMD_DESEL;
      s.cke_meta <= `CKE_RST;
      s.cke_sync <= `CKE_RST;
      s.odt_dis <= `ODT_DIS_RST;
      s.int_clk_en <= 1'b1;
      s.ck_buf_en <= 1'b1;
      s.cmd_buf_en <= 1'b1;
      s.out_drv_en <= 1'b1;
    end
    else if (ce)
      s <= next_s;
  end

  // Every output is a register bit; nothing combinational reaches a pin
  assign pwr_state = s.st;
  assign int_clk_en = s.int_clk_en;
  assign ck_buf_en = s.ck_buf_en;
  assign cmd_buf_en = s.cmd_buf_en;
  assign out_drv_en = s.out_drv_en;
  assign cmd_valid = s.cmd_valid;
  assign cmd_code = s.cmd_code;
  assign cmd_bank = s.cmd_bank;
  assign row_addr = s.row_addr;
  assign col_addr = s.col_addr;
  assign auto_pre = s.auto_pre;
  assign pre_banks = s.pre_banks;
  assign bank_open = s.bank_open;
  assign mode_wr = s.mode_wr;
  assign mode_sel = s.mode_sel;
  assign mode_op = s.mode_op;
  assign term_en = s.term_en;
  assign wr_en_rise = s.wr_en_rise;
  assign wr_en_fall = s.wr_en_fall;
endmodule : ddr2_pin_ctrl

// [test/ctl_model.sv]
// Purpose: Controller side of the command pins
// Assumes: Pins change 1 ns after the rising clock, except clock enable in set_cke, 17 ns after the call
// Notes: Deselected pins show inverted values so stale data never looks valid
`timescale 1ns/100ps
module ctl_model (
  input wire logic ref_clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [12:0] addr
);
  initial
  begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 2'h0;
    addr = 13'h0000;
  end
  task cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic k);
    @(posedge ref_clk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    cke = k;
    @(posedge ref_clk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = {1'b1, ~c[2:0]};
    ba = ~b;
    addr = ~a;
  endtask : cmd
  // Off-edge change, so only an asynchronous exit path can react early
  task set_cke(input logic k);
    #17;
    cke = k;
  endtask : set_cke
endmodule : ctl_model

// [test/ddr2_pin_chk.sv]
// Purpose: Timing relations at the pin control ports
// Assumes: ce held high; pins sampled one edge, results two edges later; write-mask results one edge after the beat
// Notes: Bound to the top module
`timescale 1ns/100ps
`include "ddr2_ctl_map.svh"
module pin_chk
  import ddr2_ctl_pkg::*;
#(parameter int ROW_W = 13, parameter int BANK_W = 2) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ROW_W-1:0] addr,
  input wire logic beat_rise,
  input wire logic [1:0] dm_rise,
  input ddr2_ctl_pkg::pwr_t pwr_state,
  input wire logic int_clk_en,
  input wire logic ck_buf_en,
  input wire logic cmd_buf_en,
  input wire logic cmd_valid,
  input ddr2_ctl_pkg::cmd_t cmd_code,
  input wire logic [ROW_W-1:0] row_addr,
  input wire logic [`COL_W-1:0] col_addr,
  input wire logic auto_pre,
  input wire logic [(1<<BANK_W)-1:0] pre_banks,
  input wire logic [(1<<BANK_W)-1:0] bank_open,
  input wire logic mode_wr,
  input wire logic [BANK_W-1:0] mode_sel,
  input wire logic [ROW_W-1:0] mode_op,
  input wire logic [1:0] wr_en_rise
);
  logic cke_q;
  localparam int NB = 1 << BANK_W;
  wire go = !cs_n && cke && cke_q && pwr_state == ST_ACTIVE;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      cke_q <= 1'b0;
    else
      cke_q <= cke;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_cke_fall;
    cke_q && !cke && pwr_state == ST_ACTIVE;
  endsequence
  a_desel_masked: assert property (cs_n |-> ##2 !cmd_valid) else $error("deselect decoded");
  a_act_decode: assert property (go && !ras_n && cas_n && we_n |-> ##2 cmd_valid &&
    cmd_code == CMD_ACT && row_addr == $past(addr, 2)) else $error("activate wrong");
  a_rd_column: assert property (go && ras_n && !cas_n && we_n |-> ##2
    col_addr == $past(addr[`COL_W-1:0], 2) && auto_pre == $past(addr[`AP_BIT], 2))
    else $error("read column wrong");
  a_pre_banks: assert property (go && !ras_n && cas_n && !we_n |-> ##2
    pre_banks == ($past(addr[`AP_BIT], 2) ? {NB{1'b1}} : NB'(1 << $past(ba, 2))))
    else $error("precharge banks wrong");
  a_mode_write: assert property (go && !ras_n && !cas_n && !we_n |-> ##2 mode_wr &&
    mode_sel == $past(ba, 2) && mode_op == $past(addr, 2)) else $error("mode write wrong");
  a_pd_entry: assert property (s_cke_fall ##0 cs_n ##1 (bank_open == 0) |-> ##1
    pwr_state == ST_PD_PRE && !int_clk_en && !cmd_buf_en && ck_buf_en)
    else $error("power down entry wrong");
  a_pd_active: assert property (s_cke_fall ##0 cs_n ##1 (bank_open != 0) |-> ##1
    pwr_state == ST_PD_ACT) else $error("active power down wrong");
  a_sref_entry: assert property (s_cke_fall ##0 (!cs_n && !ras_n && !cas_n && we_n)
    |-> ##2 pwr_state == ST_SREF && !ck_buf_en) else $error("self refresh entry wrong");
  a_mask_rise: assert property (beat_rise && int_clk_en |=>
    wr_en_rise == ~$past(dm_rise)) else $error("write mask wrong");
endmodule : pin_chk
bind ddr2_pin_ctrl pin_chk #(.ROW_W(ROW_W), .BANK_W(BANK_W)) chk_u (.ref_clk, .rst, .cke,
  .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .beat_rise, .dm_rise, .pwr_state, .int_clk_en,
  .ck_buf_en, .cmd_buf_en, .cmd_valid, .cmd_code, .row_addr, .col_addr, .auto_pre,
  .pre_banks, .bank_open, .mode_wr, .mode_sel, .mode_op, .wr_en_rise);

// [test/ddr2_pin_ctrl_tb.sv]
// Purpose: Self-checking bench for the pin control block
// Assumes: Checks land 2 ns after the edge that updates the outputs, 1 ns in the mask test and the reset check
// Notes: ce is tied high; freeze is not exercised
`timescale 1ns/100ps
module ddr2_pin_ctrl_tb;
  import ddr2_ctl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic odt = 1'b0;
  logic beat_rise = 1'b0;
  logic beat_fall = 1'b0;
  logic [1:0] dm_rise = 2'h0;
  logic [1:0] dm_fall = 2'h0;
  logic cke, cs_n, ras_n, cas_n, we_n;
  logic [1:0] ba;
  logic [12:0] addr;
  pwr_t pwr_state;
  cmd_t cmd_code;
  logic int_clk_en, ck_buf_en, cmd_buf_en, out_drv_en, cmd_valid, auto_pre, mode_wr;
  logic [1:0] cmd_bank, mode_sel, wr_en_rise, wr_en_fall;
  logic [12:0] row_addr, mode_op;
  logic [9:0] col_addr;
  logic [3:0] pre_banks, bank_open;
  logic [21:0] term_en;
  int failures = 0;
  int checked = 0;
  always #20 ref_clk = ~ref_clk;
  ctl_model ctl_u (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr));
  ddr2_pin_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt), .ba(ba), .addr(addr),
    .beat_rise(beat_rise), .beat_fall(beat_fall), .dm_rise(dm_rise), .dm_fall(dm_fall),
    .pwr_state(pwr_state), .int_clk_en(int_clk_en), .ck_buf_en(ck_buf_en),
    .cmd_buf_en(cmd_buf_en), .out_drv_en(out_drv_en), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_bank(cmd_bank), .row_addr(row_addr), .col_addr(col_addr),
    .auto_pre(auto_pre), .pre_banks(pre_banks), .bank_open(bank_open), .mode_wr(mode_wr),
    .mode_sel(mode_sel), .mode_op(mode_op), .term_en(term_en), .wr_en_rise(wr_en_rise),
    .wr_en_fall(wr_en_fall));
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // Returns once the decoded outputs of this command have landed
  task go(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic k);
    ctl_u.cmd(c, b, a, k);
    @(posedge ref_clk);
    #2;
  endtask : go
  task t_decode;
    logic [3:0] codes [4];
    codes = '{4'h4, 4'h1, 4'h6, 4'h7};
    go(4'h3, 2'h1, 13'h1abc, 1'b1);
    chk(cmd_code, CMD_ACT);
    chk(row_addr, 13'h1abc);
    chk(bank_open, 4'h2);
    go(4'h5, 2'h1, 13'h0523, 1'b1);
    chk({cmd_bank, auto_pre, col_addr}, {2'h1, 1'b1, 10'h123});
    go(4'h2, 2'h1, 13'h0000, 1'b1);
    chk({pre_banks, bank_open}, {4'h2, 4'h0});
    go(4'h3, 2'h3, 13'h0011, 1'b1);
    go(4'h2, 2'h0, 13'h0400, 1'b1);
    chk({pre_banks, bank_open}, {4'hf, 4'h0});
    go(4'hf, 2'h2, 13'h0000, 1'b1);
    chk({cmd_valid, cmd_code}, {1'b0, CMD_DESEL});
    foreach (codes[i])
    begin
      go(codes[i], 2'h0, 13'h0000, 1'b1);
      chk({cmd_valid, cmd_code}, {codes[i] != 4'h7, codes[i]});
    end
    $display("decode test done");
  endtask : t_decode
  task t_mode;
    odt = 1'b1;
    go(4'h0, 2'h1, 13'h0000, 1'b1);
    chk({mode_wr, mode_sel, mode_op}, {1'b1, 2'h1, 13'h0000});
    repeat (3) @(posedge ref_clk);
    #2;
    chk(term_en, 22'h0);
    go(4'h0, 2'h1, 13'h0004, 1'b1);
    repeat (3) @(posedge ref_clk);
    #2;
    chk(term_en, 22'h3fffff);
    odt = 1'b0;
    $display("mode test done");
  endtask : t_mode
  task t_mask;
    beat_rise = 1'b1;
    beat_fall = 1'b1;
    dm_rise = 2'h2;
    dm_fall = 2'h1;
    @(posedge ref_clk);
    #1;
    beat_rise = 1'b0;
    beat_fall = 1'b0;
    chk({wr_en_rise, wr_en_fall}, {2'h1, 2'h2});
    $display("mask test done");
  endtask : t_mask
  task t_power;
    go(4'hf, 2'h0, 13'h0000, 1'b0);
    chk({pwr_state, int_clk_en, cmd_buf_en, ck_buf_en}, {ST_PD_PRE, 3'b001});
    go(4'hf, 2'h0, 13'h0000, 1'b1);
    chk({pwr_state, out_drv_en}, {ST_ACTIVE, 1'b1});
    go(4'h3, 2'h0, 13'h0005, 1'b1);
    go(4'hf, 2'h0, 13'h0000, 1'b0);
    chk(pwr_state, ST_PD_ACT);
    go(4'hf, 2'h0, 13'h0000, 1'b1);
    go(4'h2, 2'h0, 13'h0400, 1'b1);
    go(4'h1, 2'h0, 13'h0000, 1'b0);
    chk({pwr_state, ck_buf_en}, {ST_SREF, 1'b0});
    ctl_u.set_cke(1'b1);
    repeat (4) @(posedge ref_clk);
    #2;
    chk(pwr_state, ST_ACTIVE);
    $display("power test done");
  endtask : t_power
  task results;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  initial
  begin
    #100000;
    failures++;
    results();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    chk({pwr_state, cmd_code, int_clk_en, out_drv_en}, {ST_ACTIVE, CMD_DESEL, 2'b11});
    t_decode();
    t_mode();
    t_mask();
    t_power();
    results();
  end
endmodule : ddr2_pin_ctrl_tb
